// ===== logic/sewa_host.sv
// host end: register driven controller for the serial eeprom link
// assumes a software master on the plain register port, same clock
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

module sewa_host #(
  parameter int unsigned ERASE_CYC = sewa_pkg::ERASE_CYC,
  parameter int unsigned WRITE_CYC = sewa_pkg::WRITE_CYC
) (
  input  wire logic                      SYS_CLK_I,
  input  wire logic                      NRST_I,
  input  wire logic [sewa_pkg::RA_W-1:0] ADDR_I,
  input  wire logic [31:0]               WDATA_I,
  input  wire logic                      WR_I,
  input  wire logic                      RD_I,
  output logic [31:0]                    RDATA_O,
  sewa_link_if.host                      LINK
);
  localparam int unsigned DW = sewa_pkg::DATA_W;
  localparam int unsigned TW = sewa_pkg::TMR_W;
  localparam logic [TW-1:0] HALF_T  = TW'(sewa_pkg::HALF_CYC - 1);
  localparam logic [TW-1:0] ERASE_T = TW'(ERASE_CYC - 1);
  localparam logic [TW-1:0] WRITE_T = TW'(WRITE_CYC - 1);

  typedef struct packed {
    sewa_pkg::sewa_hst_e         st;
    sewa_pkg::sewa_act_e         act;
    logic [TW-1:0]               tmr;
    logic [sewa_pkg::CNT_W-1:0]  cnt;
    logic [DW-1:0]               sr;
    logic [DW-1:0]               rx;
    logic [sewa_pkg::CMD_W-1:0]  cmd;
    logic [DW-1:0]               wd;
    logic                        sclk;
    logic                        sel;
    logic                        dat;
    logic                        dat_oe_n;
    logic [31:0]                 rdata;
  } sewa_host_s;

  sewa_host_s q_ff;
  sewa_host_s nxt_q;
  logic       line_s;
  logic       tick;
  logic [sewa_pkg::CNT_W-1:0] len;
  logic [sewa_pkg::CNT_W-1:0] cnt_inc;

  sewa_sync #(
    .W (1)
  ) u_sync (
    .sys_clk_i (SYS_CLK_I),
    .nrst_i    (NRST_I),
    .async_i   (LINK.serial_addr_data_line),
    .sync_o    (line_s)
  );

  assign tick    = q_ff.tmr == HALF_T;
  assign len     = q_ff.act == sewa_pkg::ACT_ADDR ? sewa_pkg::CMD_BITS
                                                  : sewa_pkg::DATA_BITS;
  assign cnt_inc = q_ff.cnt + 1'b1;

  // ==========================================================
  // register port and sequencer
  always_comb begin
    nxt_q       = q_ff;
    nxt_q.rdata = '0;
    if (RD_I) begin
      unique case (ADDR_I)
        sewa_pkg::RA_CMD:    nxt_q.rdata = {20'h00000, q_ff.cmd};
        sewa_pkg::RA_WDATA:  nxt_q.rdata = q_ff.wd;
        sewa_pkg::RA_STATUS: nxt_q.rdata = {30'h00000000, q_ff.sel,
                                  q_ff.st != sewa_pkg::HS_IDLE};
        sewa_pkg::RA_RDATA:  nxt_q.rdata = q_ff.rx;
        default:             nxt_q.rdata = '0;
      endcase
    end
    if (WR_I && ADDR_I == sewa_pkg::RA_CMD) begin
      nxt_q.cmd = WDATA_I[sewa_pkg::CMD_W-1:0];
    end
    if (WR_I && ADDR_I == sewa_pkg::RA_WDATA) begin
      nxt_q.wd = WDATA_I;
    end

    if (q_ff.st != sewa_pkg::HS_IDLE) begin
      nxt_q.tmr = tick ? '0 : q_ff.tmr + 1'b1;
    end

    unique case (q_ff.st)
      sewa_pkg::HS_IDLE: begin
        // start requests while busy are dropped
        if (WR_I && ADDR_I == sewa_pkg::RA_GO) begin
          nxt_q.act = sewa_pkg::sewa_act_e'(WDATA_I[2:0]);
          nxt_q.tmr = '0;
          nxt_q.cnt = '0;
          unique case (sewa_pkg::sewa_act_e'(WDATA_I[2:0]))
            sewa_pkg::ACT_ADDR: begin
              nxt_q.sel      = 1'b1;
              nxt_q.sr       = {q_ff.cmd, 20'h00000};
              nxt_q.dat_oe_n = 1'b0;
              nxt_q.st       = sewa_pkg::HS_SETUP;
            end
            sewa_pkg::ACT_DATA: begin
              nxt_q.sel      = 1'b0;
              nxt_q.sr       = q_ff.wd;
              nxt_q.dat_oe_n = 1'b0;
              nxt_q.st       = sewa_pkg::HS_SETUP;
            end
            sewa_pkg::ACT_READ: begin
              nxt_q.sel = 1'b0;
              nxt_q.st  = sewa_pkg::HS_SETUP;
            end
            sewa_pkg::ACT_ERASE,
            sewa_pkg::ACT_WRITE: begin
              nxt_q.sel = 1'b0;
              nxt_q.st  = sewa_pkg::HS_HOLD;
            end
            sewa_pkg::ACT_PARK: nxt_q.sel = 1'b0;
            default:            nxt_q.act = sewa_pkg::ACT_NONE;
          endcase
        end
      end
      sewa_pkg::HS_SETUP: begin
        if (tick) begin
          if (q_ff.act == sewa_pkg::ACT_READ) begin
            // first bit is on the line before any pulse
            nxt_q.rx  = {q_ff.rx[DW-2:0], line_s};
            nxt_q.cnt = 6'h01;
          end
          nxt_q.dat  = q_ff.sr[DW-1];
          nxt_q.sclk = 1'b1;
          nxt_q.st   = sewa_pkg::HS_HIGH;
        end
      end
      sewa_pkg::HS_HIGH: begin
        if (tick) begin
          nxt_q.sclk = 1'b0;
          nxt_q.sr   = {q_ff.sr[DW-2:0], 1'b0};
          nxt_q.st   = sewa_pkg::HS_LOW;
        end
      end
      sewa_pkg::HS_LOW: begin
        if (tick) begin
          // 31 further pulses on read
          // the last low phase still carries bit zero of the word
          if (q_ff.act == sewa_pkg::ACT_READ) begin
            nxt_q.rx = {q_ff.rx[DW-2:0], line_s};
          end
          nxt_q.cnt = cnt_inc;
          if (cnt_inc == len) begin
            nxt_q.dat_oe_n = 1'b1;
            nxt_q.sel      = 1'b1;
            nxt_q.st       = sewa_pkg::HS_IDLE;
          end else begin
            nxt_q.dat  = q_ff.sr[DW-1];
            nxt_q.sclk = 1'b1;
            nxt_q.st   = sewa_pkg::HS_HIGH;
          end
        end
      end
      sewa_pkg::HS_HOLD: begin
        nxt_q.tmr = q_ff.tmr + 1'b1;
        if ((q_ff.act == sewa_pkg::ACT_ERASE && q_ff.tmr == ERASE_T) ||
            (q_ff.act == sewa_pkg::ACT_WRITE && q_ff.tmr == WRITE_T)) begin
          nxt_q.sel = 1'b1;
          nxt_q.tmr = '0;
          nxt_q.st  = sewa_pkg::HS_IDLE;
        end
      end
      default: nxt_q.st = sewa_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q_ff          <= '0;
      q_ff.sel      <= 1'b1;
      q_ff.dat_oe_n <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign RDATA_O                   = q_ff.rdata;
  assign LINK.shift_clock_pin      = q_ff.sclk;
  assign LINK.register_select_line = q_ff.sel;
  assign LINK.host_dat             = q_ff.dat;
  assign LINK.host_dat_oe_n        = q_ff.dat_oe_n;

endmodule : sewa_host

`default_nettype wire

// ===== shared/sewa_pkg.sv
// constants and types shared by both ends of the serial eeprom link
// assumes a single 10 MHz system clock on every end
package sewa_pkg;

  // ==========================================================
  // clock and link timing
  localparam int unsigned CLK_HZ    = 10_000_000;
  localparam int unsigned ERASE_MS  = 100;
  localparam int unsigned WRITE_MS  = 10;
  localparam int unsigned ERASE_CYC = CLK_HZ / 1000 * ERASE_MS;
  localparam int unsigned WRITE_CYC = CLK_HZ / 1000 * WRITE_MS;
  // half shift clock period, keeps high and low phases above 4 us
  localparam int unsigned HALF_NS   = 5000;
  localparam int unsigned HALF_CYC  =
    (HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned TMR_W     = 20;

  // ==========================================================
  // command word and array layout
  localparam int unsigned CMD_W   = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned WORDS   = 32;
  localparam int unsigned WA_W    = 5;
  localparam int unsigned ID_W    = 4;
  localparam int unsigned OP_W    = 3;
  localparam int unsigned ID_LSB  = 8;
  localparam int unsigned WA_LSB  = 3;
  localparam int unsigned OP_LSB  = 0;
  localparam int unsigned CNT_W   = 6;
  localparam logic [CNT_W-1:0] CMD_BITS  = 6'h0C;
  localparam logic [CNT_W-1:0] DATA_BITS = 6'h20;

  // operation field as {first, second, third}; third bit set = standby
  localparam logic [OP_W-1:0] OP_READ   = 3'h0;
  localparam logic [OP_W-1:0] OP_WERASE = 3'h2;
  localparam logic [OP_W-1:0] OP_BERASE = 3'h6;
  localparam logic [OP_W-1:0] OP_WRITE  = 3'h4;
  localparam int unsigned     OP_STBY_BIT = 0;

  // ==========================================================
  // host controller registers, byte offsets on the plain port
  localparam int unsigned   RA_W      = 5;
  localparam logic [RA_W-1:0] RA_CMD    = 5'h00;
  localparam logic [RA_W-1:0] RA_WDATA  = 5'h04;
  localparam logic [RA_W-1:0] RA_GO     = 5'h08;
  localparam logic [RA_W-1:0] RA_STATUS = 5'h0C;
  localparam logic [RA_W-1:0] RA_RDATA  = 5'h10;

  typedef enum logic [2:0] {
    ACT_NONE  = 3'b000,
    ACT_ADDR  = 3'b001,
    ACT_DATA  = 3'b010,
    ACT_READ  = 3'b011,
    ACT_ERASE = 3'b100,
    ACT_WRITE = 3'b101,
    ACT_PARK  = 3'b110
  } sewa_act_e;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_SETUP = 3'b001,
    HS_HIGH  = 3'b010,
    HS_LOW   = 3'b011,
    HS_HOLD  = 3'b100
  } sewa_hst_e;

endpackage : sewa_pkg

// ===== shared/sewa_link_if.sv
// serial link between host controller and eeprom device end
// the resolved line levels stand in for the board wiring
`timescale 1ns/1ps
`default_nettype none

interface sewa_link_if;
  logic shift_clock_pin;
  logic register_select_line;
  logic host_dat;
  logic host_dat_oe_n;
  logic dev_dat;
  logic dev_dat_oe_n;
  logic prog_sw_dat;
  logic prog_sw_oe_n;
  logic serial_addr_data_line;
  logic prog_supply_switch_out;

  // ==========================================================
  // line resolution, an undriven line floats high via a pull-up
  assign serial_addr_data_line = !dev_dat_oe_n  ? dev_dat  :
                                 !host_dat_oe_n ? host_dat : 1'b1;
  assign prog_supply_switch_out = !prog_sw_oe_n ? prog_sw_dat : 1'b1;

  modport host (
    output shift_clock_pin,
    output register_select_line,
    output host_dat,
    output host_dat_oe_n,
    input  serial_addr_data_line
  );

  modport dev (
    input  shift_clock_pin,
    input  register_select_line,
    input  serial_addr_data_line,
    output dev_dat,
    output dev_dat_oe_n,
    output prog_sw_dat,
    output prog_sw_oe_n
  );
endinterface : sewa_link_if

`default_nettype wire

// ===== logic/sewa_sync.sv
// three stage input synchroniser, one lane per bit
// assumes inputs are asynchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none

module sewa_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // ==========================================================
  // a change is taken only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_lane
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        s1_ff[i]  <= 1'b0;
        s2_ff[i]  <= 1'b0;
        s3_ff[i]  <= 1'b0;
        sync_o[i] <= 1'b0;
      end else begin
        s1_ff[i] <= async_i[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i]) begin
          sync_o[i] <= s3_ff[i];
        end
      end
    end
  end

endmodule : sewa_sync

`default_nettype wire

// ===== logic/sewa_dev.sv
// device end: 32 x 32 bit serial eeprom word access logic
// assumes link pins arrive asynchronously; array held in flip-flops
`timescale 1ns/1ps
`default_nettype none

module sewa_dev (
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  NRST_I,
  input  wire logic [sewa_pkg::ID_W-1:0] CHIP_ID_I,
  input  wire logic                  SUPPLY_OK_I,
  output logic                       SELECTED_O,
  output logic                       STANDBY_O,
  sewa_link_if.dev                   LINK
);
  localparam int unsigned DW = sewa_pkg::DATA_W;
  localparam int unsigned CW = sewa_pkg::CMD_W;
  localparam int unsigned SW = sewa_pkg::ID_W + 4;

  typedef struct packed {
    logic [sewa_pkg::WORDS-1:0][DW-1:0] mem;
    logic [CW-1:0]                      cmd;
    logic [DW-1:0]                      data;
    logic                               load_act;
    logic                               clk_seen;
    logic                               clk_q;
    logic                               sel_q;
    logic                               dout;
    logic                               dout_oe_n;
    logic                               prog_oe_n;
  } sewa_dev_s;

  sewa_dev_s q_ff;
  sewa_dev_s nxt_q;

  logic [SW-1:0]               pins_s;
  logic                        clk_s;
  logic                        sel_s;
  logic                        line_s;
  logic                        supply_s;
  logic [sewa_pkg::ID_W-1:0]   id_s;
  logic [sewa_pkg::OP_W-1:0]   op;
  logic [sewa_pkg::WA_W-1:0]   waddr;
  logic                        id_match;
  logic                        stby;
  logic                        op_read;
  logic                        op_prog;
  logic                        fall;

  // ==========================================================
  // pin synchronisers
  sewa_sync #(
    .W (SW)
  ) u_sync (
    .sys_clk_i (SYS_CLK_I),
    .nrst_i    (NRST_I),
    .async_i   ({CHIP_ID_I, SUPPLY_OK_I, LINK.serial_addr_data_line,
                 LINK.register_select_line, LINK.shift_clock_pin}),
    .sync_o    (pins_s)
  );

  assign clk_s    = pins_s[0];
  assign sel_s    = pins_s[1];
  assign line_s   = pins_s[2];
  assign supply_s = pins_s[3];
  assign id_s     = pins_s[SW-1:4];

  // ==========================================================
  // command decode
  // field positions
  assign op    = q_ff.cmd[sewa_pkg::OP_LSB +: sewa_pkg::OP_W];
  assign waddr = q_ff.cmd[sewa_pkg::WA_LSB +: sewa_pkg::WA_W];
  assign id_match = q_ff.cmd[sewa_pkg::ID_LSB +: sewa_pkg::ID_W] == id_s;
  assign stby = op[sewa_pkg::OP_STBY_BIT] | sel_s;
  assign op_read = !stby && (op == sewa_pkg::OP_READ);
  assign op_prog = !op[sewa_pkg::OP_STBY_BIT] &&
                   (op == sewa_pkg::OP_WERASE ||
                    op == sewa_pkg::OP_BERASE ||
                    op == sewa_pkg::OP_WRITE);
  assign fall = q_ff.clk_q & !clk_s;

  // ==========================================================
  // next state
  always_comb begin
    nxt_q       = q_ff;
    nxt_q.clk_q = clk_s;
    nxt_q.sel_q = sel_s;

    if (q_ff.sel_q && !sel_s) begin
      nxt_q.clk_seen = 1'b0;
      nxt_q.load_act = id_match && !op[sewa_pkg::OP_STBY_BIT] &&
                       (op == sewa_pkg::OP_READ);
    end
    if (q_ff.load_act) begin
      nxt_q.data = q_ff.mem[waddr];
    end

    if (fall) begin
      nxt_q.clk_seen = 1'b1;
      if (sel_s) begin
        nxt_q.cmd = {q_ff.cmd[CW-2:0], line_s};
      end else if (q_ff.load_act || (op_read && id_match)) begin
        nxt_q.load_act = 1'b0;
        nxt_q.data = {q_ff.data[DW-2:0], q_ff.data[DW-1]};
      end else begin
        nxt_q.data = {q_ff.data[DW-2:0], line_s};
      end
    end

    // a clock-free low interval ending is the program or erase pulse;
    // intervals that carried shift clocks were data transfers
    // array acts only when selected
    if (!q_ff.sel_q && sel_s && !q_ff.clk_seen && id_match &&
        supply_s && op_prog) begin
      unique case (op)
        sewa_pkg::OP_WERASE: nxt_q.mem[waddr] = '0;
        sewa_pkg::OP_BERASE: nxt_q.mem = '0;
        sewa_pkg::OP_WRITE:  nxt_q.mem[waddr] = q_ff.data;
        default:             nxt_q.mem = q_ff.mem;
      endcase
    end

    nxt_q.dout_oe_n = !(op_read && id_match);
    nxt_q.dout = nxt_q.data[DW-1];
    nxt_q.prog_oe_n = !(supply_s && id_match && op_prog && !sel_s);
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q_ff           <= '0;
      q_ff.clk_seen  <= 1'b1;
      q_ff.dout_oe_n <= 1'b1;
      q_ff.prog_oe_n <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ==========================================================
  // outputs
  assign LINK.dev_dat      = q_ff.dout;
  assign LINK.dev_dat_oe_n = q_ff.dout_oe_n;
  assign LINK.prog_sw_dat  = 1'b0;
  assign LINK.prog_sw_oe_n = q_ff.prog_oe_n;
  assign SELECTED_O        = !q_ff.dout_oe_n || !q_ff.prog_oe_n;
  assign STANDBY_O         = q_ff.sel_q ||
                             q_ff.cmd[sewa_pkg::OP_LSB +
                                      sewa_pkg::OP_STBY_BIT];

endmodule : sewa_dev

`default_nettype wire

// ===== sim/sewa_link_assertions.sv
// concurrent checks on the link between host end and device end
// assumes plain link signals and the one system clock of both ends
`timescale 1ns/1ps
`default_nettype none

module sewa_link_assertions (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic shift_clock_pin,
  input wire logic register_select_line,
  input wire logic host_dat,
  input wire logic host_dat_oe_n,
  input wire logic dev_dat,
  input wire logic dev_dat_oe_n,
  input wire logic prog_sw_dat,
  input wire logic prog_sw_oe_n,
  input wire logic serial_addr_data_line,
  input wire logic prog_supply_switch_out
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  // ==========================================================
  // high phase length, saturates so a stuck clock cannot wrap
  logic [7:0] hi_cnt_ff;
  logic [7:0] nxt_hi_cnt;
  always_comb begin
    nxt_hi_cnt = 8'h00;
    if (shift_clock_pin) begin
      nxt_hi_cnt = (hi_cnt_ff == 8'hFF) ? hi_cnt_ff : hi_cnt_ff + 8'h01;
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hi_cnt_ff <= 8'h00;
    end else begin
      hi_cnt_ff <= nxt_hi_cnt;
    end
  end

  // ==========================================================
  // link checks
  a_no_line_fight: assert property (!(!dev_dat_oe_n && !host_dat_oe_n))
    else $error("both ends drive the serial line");
  a_rise_releases: assert property ($rose(register_select_line) |->
    ##[1:8] (dev_dat_oe_n && prog_sw_oe_n))
    else $error("device still drives after select rose");
  a_idle_no_drive: assert property (register_select_line [*8] |->
    dev_dat_oe_n) else $error("device drives in command mode");
  a_sw_idle_off: assert property (register_select_line [*8] |->
    prog_sw_oe_n) else $error("supply switch on in command mode");
  a_sw_pull_low: assert property (!prog_sw_dat &&
    (prog_supply_switch_out == prog_sw_oe_n))
    else $error("supply switch drives high");
  a_out_held_high: assert property (
    shift_clock_pin && $past(shift_clock_pin) && !dev_dat_oe_n &&
    !$past(dev_dat_oe_n) |-> $stable(dev_dat))
    else $error("device bit moved while clock high");
  a_host_bit_hold: assert property ($changed(host_dat) && !host_dat_oe_n
    && !$past(host_dat_oe_n) |-> $rose(shift_clock_pin))
    else $error("host bit moved away from clock rise");
  a_clk_high_span: assert property ($fell(shift_clock_pin) |->
    hi_cnt_ff >= 8'h28) else $error("shift clock high phase too short");
endmodule : sewa_link_assertions

`default_nettype wire

// ===== sim/tb.sv
// self-checking bench: host end and device end joined by the link
// assumes host erase and write holds shortened to 200 and 100 cycles
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [3:0] CHIP_ID = 4'hA;
  logic        sys_clk   = 1'b0;
  logic        nrst      = 1'b0;
  logic [4:0]  addr      = 5'h00;
  logic [31:0] wdata     = 32'h0000_0000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        supply_ok = 1'b1;
  logic [31:0] rdata;
  logic        selected;
  logic        standby;
  logic [31:0] seed      = 32'h0000_F7E2;
  logic [2:0]  cur_op    = 3'h0;
  logic        cur_idok  = 1'b1;
  int          failures  = 0;
  int          checked   = 0;

  always #50 sys_clk = ~sys_clk;

  sewa_link_if link ();
  sewa_host #(.ERASE_CYC(200), .WRITE_CYC(100)) u_sewa_host (
    .SYS_CLK_I(sys_clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LINK(link));
  sewa_dev u_sewa_dev (
    .SYS_CLK_I(sys_clk), .NRST_I(nrst), .CHIP_ID_I(CHIP_ID),
    .SUPPLY_OK_I(supply_ok), .SELECTED_O(selected), .STANDBY_O(standby),
    .LINK(link));
  sewa_link_assertions u_sewa_link_assertions (
    .SYS_CLK_I(sys_clk), .NRST_I(nrst),
    .shift_clock_pin(link.shift_clock_pin),
    .register_select_line(link.register_select_line),
    .host_dat(link.host_dat), .host_dat_oe_n(link.host_dat_oe_n),
    .dev_dat(link.dev_dat), .dev_dat_oe_n(link.dev_dat_oe_n),
    .prog_sw_dat(link.prog_sw_dat), .prog_sw_oe_n(link.prog_sw_oe_n),
    .serial_addr_data_line(link.serial_addr_data_line),
    .prog_supply_switch_out(link.prog_supply_switch_out));

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // switch on only for program ops, id match, supply, select low
  function automatic logic sw_off(input logic [2:0] code);
    logic prog;
    prog = (cur_op == sewa_pkg::OP_WRITE) || (cur_op == sewa_pkg::OP_WERASE)
      || (cur_op == sewa_pkg::OP_BERASE);
    return !(prog && cur_idok && supply_ok && code >= 3'h2);
  endfunction
  // selected when the switch is on, or the driver is on for a matching read in data mode
  function automatic logic sel_exp(input logic [2:0] code);
    return !sw_off(code) ||
      (code == 3'h3 && cur_op == sewa_pkg::OP_READ && cur_idok);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: seen %08h expected %08h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // register port and link operations
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  // park leaves the controller idle, so it is not polled
  task automatic go(input logic [2:0] code);
    logic [31:0] st;
    int          n;
    wr_reg(sewa_pkg::RA_GO, {29'h0, code});
    repeat (20) @(posedge sys_clk);
    #1;
    chk({31'h0, link.prog_supply_switch_out},
        {31'h0, sw_off(code)});
    chk({31'h0, selected}, {31'h0, sel_exp(code)});
    st = 32'h0000_0001;
    n = 0;
    while (code != 3'h6 && st[0] !== 1'b0 && n < 4000) begin
      rd_reg(sewa_pkg::RA_STATUS, st);
      n++;
    end
    if (n >= 4000) failures++;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  // command word order id, word address, operation
  task automatic load(input logic [3:0] id, input logic [4:0] wa,
                      input logic [2:0] op);
    wr_reg(sewa_pkg::RA_CMD, {20'h0, id, wa, op});
    cur_op   = op;
    cur_idok = (id === CHIP_ID);
    go(3'h1);
  endtask
  task automatic get_word(input logic [4:0] wa, input logic [31:0] exp);
    logic [31:0] d;
    load(CHIP_ID, wa, sewa_pkg::OP_READ);
    go(3'h3);
    rd_reg(sewa_pkg::RA_RDATA, d);
    chk(d, exp);
  endtask
  // new word shifted in before the write hold
  task automatic put_word(input logic [3:0] id, input logic [4:0] wa,
                          input logic [31:0] d);
    load(id, wa, sewa_pkg::OP_WRITE);
    wr_reg(sewa_pkg::RA_WDATA, d);
    go(3'h2);
    go(3'h5);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] st;
    logic [4:0]  a2;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rd_reg(sewa_pkg::RA_STATUS, st);
    chk(st, 32'h0000_0002);
    rd_reg(5'h14, st);
    chk(st, 32'h0000_0000);
    chk({31'h0, standby}, 32'h0000_0001);
    get_word(5'h00, 32'h0000_0000);
    seed = xs(seed);
    w1 = seed;
    seed = xs(seed);
    w2 = seed;
    a2 = {seed[4:1], 1'b0};
    put_word(CHIP_ID, 5'h1F, w1);
    get_word(5'h1F, w1);
    put_word(CHIP_ID, a2, w2);
    get_word(a2, w2);
    load(CHIP_ID, 5'h1F, sewa_pkg::OP_WERASE);
    go(3'h4);
    get_word(5'h1F, 32'h0000_0000);
    get_word(a2, w2);
    // foreign id first, then missing supply: both must leave the word
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      supply_ok <= (k == 0);
      put_word((k == 0) ? ~CHIP_ID : CHIP_ID, a2, ~w2);
      get_word(a2, w2);
    end
    @(posedge sys_clk);
    supply_ok <= 1'b1;
    load(CHIP_ID, 5'h00, sewa_pkg::OP_BERASE);
    go(3'h4);
    get_word(a2, 32'h0000_0000);
    load(CHIP_ID, a2, 3'h5);
    go(3'h6);
    chk({31'h0, standby}, 32'h0000_0001);
    conclude();
  end

  initial begin
    repeat (80000) @(posedge sys_clk);
    failures++;
    conclude();
  end
endmodule : tb

`default_nettype wire
